// file: vsc_proc_ctrl.v
// Format code register and processing-feature gating for the video transmit path
`include "vsc_defs.vh"

// What this block does
// [R1] Detected standard reported as read-only five-bit code field, bits 14 to 10.
// [R2] Code 08h for 720p24, 09h for its extended variant, 4125 samples.
// [R3] Codes 0Ah,0Ch interlaced or PsF; 0Bh,0Dh progressive; 0Eh extended 25p.
// [R4] Code 0Fh for extended 1080 25 PsF, 2640 samples.
// [R5] Codes 10h, 11h, 12h for 1080 24p, 24PsF, extended 24p.
// [R6] Code 13h extended 24PsF, 14h for 2376-sample 50i, 15h for 1035i.
// [R7] Codes 16h,17h for 525 SD 487/507, 19h,1Bh for generic 525.
// [R8] 18h 625 SD, 1Ah generic 625, 1Dh unknown HD, 1Eh unknown SD.
// [R9] 59.94 and 60 Hz variants share one code.
// [R10] Insertion features act only in SMPTE mode with processing enable high.
// [R11] Disable bits reset to zero; each set bit disables only its feature.
// [R12] Bit 8 picks active-line blanking or TRS H bit for horizontal timing.
// [R13] Payload id packets in luma only, HD, when any id byte nonzero.
// [R14] Bit 5 low enables illegal code correction in active picture.
// [R15] Bit 4 low enables error-detection packets in SD mode.
// [R16] Bit 3 low enables ancillary checksum insertion.
// [R17] Bit 2 low enables line CRC words, luma in HD and SD, chroma in HD only.
// [R18] Bit 1 low enables line numbers in luma and chroma, HD only.
// [R19] Bit 0 low enables timing words only with both pins high.
// [R20] Controller holds processing enable and bypass pins high for features to act.
// [R21] Bits 15 to 9 and bit 7 of the disable register read zero.
module vsc_proc_ctrl (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Register port
   input  wire [11:0] reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // Control pins
   input  wire        processing_enable_pin,
   input  wire        coding_bypass_pin,
   input  wire        sd_mode,
   // Raster measurement from the flywheel
   input  wire        raster_valid,
   input  wire        flywheel_locked,
   input  wire [12:0] total_samples,
   input  wire [11:0] active_samples,
   input  wire [10:0] active_lines,
   input  wire        interlaced,
   input  wire        segmented,
   // Timing and stream context
   input  wire        h_blank_active,
   input  wire        h_trs_bit,
   input  wire        in_active_picture,
   // Feature enables toward the insertion datapath
   output reg         h_timing,
   output reg         timing_ref_en,
   output reg         line_number_en,
   output reg         line_crc_luma_en,
   output reg         line_crc_chroma_en,
   output reg         anc_checksum_en,
   output reg         error_packet_en,
   output reg         remap_en,
   output reg         payload_id_luma_en,
   output reg  [4:0]  video_format_code
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg  [15:0] processing_disable;
   reg  [15:0] payload_id_a;
   reg  [15:0] payload_id_b;
   reg         std_lock;
   reg         std_interlaced;
   wire [4:0]  class_code;

   // Named disable fields
   wire timing_ref_insert_off  = processing_disable[`VSC_BIT_TRS];
   wire line_number_insert_off = processing_disable[`VSC_BIT_LNUM];
   wire line_crc_insert_off    = processing_disable[`VSC_BIT_CRC];
   wire anc_checksum_insert_off = processing_disable[`VSC_BIT_ANC];
   wire error_packet_insert_off = processing_disable[`VSC_BIT_EDH];
   wire remap_off              = processing_disable[`VSC_BIT_REMAP];
   wire payload_id_insert_off  = processing_disable[`VSC_BIT_PID];
   wire h_config               = processing_disable[`VSC_BIT_HCFG];

   // ---------------------------------------------------------------
   // Format classifier
   // ---------------------------------------------------------------
   vsc_classify u_classify (
      .total_samples  (total_samples),
      .active_samples (active_samples),
      .active_lines   (active_lines),
      .interlaced     (interlaced),
      .segmented      (segmented),
      .sd_mode        (sd_mode),
      .code           (class_code)
   );

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   // Unused bits are masked on write so they always read back zero
   always @(posedge clk) begin
      if (rst) begin
         processing_disable <= `VSC_PROC_DIS_RST; // R11
         payload_id_a       <= 16'h0000;
         payload_id_b       <= 16'h0000;
      end else if (reg_wr) begin
         case (reg_addr)
            `VSC_ADDR_PROC_DIS: processing_disable <= reg_wdata & `VSC_PROC_DIS_MASK; // R21
            `VSC_ADDR_FMT_A:    payload_id_a <= reg_wdata;
            `VSC_ADDR_FMT_B:    payload_id_b <= reg_wdata;
            default:            ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Standard status capture
   // ---------------------------------------------------------------
   // Code clears while bypassed or unlocked; lock flag follows flywheel
   always @(posedge clk) begin
      if (rst) begin
         video_format_code <= 5'h00;
         std_interlaced    <= 1'b0;
         std_lock          <= 1'b0;
      end else begin
         std_lock <= flywheel_locked;
         if (!coding_bypass_pin || !flywheel_locked) begin
            video_format_code <= 5'h00;
            std_interlaced    <= 1'b0;
         end else if (raster_valid) begin
            video_format_code <= class_code; // R1 R2 R3 R4 R5 R6 R7 R8 R9
            std_interlaced    <= interlaced;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register reads, data valid the cycle after the strobe
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `VSC_ADDR_PROC_DIS: reg_rdata <= processing_disable; // R21
            `VSC_ADDR_STD:      reg_rdata <= {1'b0, video_format_code, std_interlaced,
                                              std_lock, 8'h00}; // R1
            `VSC_ADDR_FMT_A:    reg_rdata <= payload_id_a;
            `VSC_ADDR_FMT_B:    reg_rdata <= payload_id_b;
            default:            reg_rdata <= 16'h0000; // Unmapped reads zero
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // Feature gating
   // ---------------------------------------------------------------
   // Both pins must be high; a trade-off is that enables lag the pins one cycle
   wire proc_on = processing_enable_pin & coding_bypass_pin; // R10 R20
   wire pid_nonzero = |{payload_id_a, payload_id_b};

   always @(posedge clk) begin
      if (rst) begin
         h_timing           <= 1'b0;
         timing_ref_en      <= 1'b0;
         line_number_en     <= 1'b0;
         line_crc_luma_en   <= 1'b0;
         line_crc_chroma_en <= 1'b0;
         anc_checksum_en    <= 1'b0;
         error_packet_en    <= 1'b0;
         remap_en           <= 1'b0;
         payload_id_luma_en <= 1'b0;
      end else begin
         h_timing           <= h_config ? h_trs_bit : h_blank_active; // R12
         timing_ref_en      <= proc_on & ~timing_ref_insert_off; // R19
         line_number_en     <= proc_on & ~sd_mode & ~line_number_insert_off; // R18
         line_crc_luma_en   <= proc_on & ~line_crc_insert_off; // R17
         line_crc_chroma_en <= proc_on & ~sd_mode & ~line_crc_insert_off; // R17
         anc_checksum_en    <= proc_on & ~anc_checksum_insert_off; // R16
         error_packet_en    <= proc_on & sd_mode & ~error_packet_insert_off; // R15
         remap_en           <= proc_on & in_active_picture & ~remap_off; // R14
         payload_id_luma_en <= proc_on & ~sd_mode & pid_nonzero
                               & ~payload_id_insert_off; // R13
      end
   end
endmodule

// file: vsc_defs.vh
// Register offsets, field positions, reset values and format codes for the video standard block
`ifndef VSC_DEFS_VH
`define VSC_DEFS_VH
// ---------------------------------------------------------------
// Register offsets (word addresses)
// ---------------------------------------------------------------
`define VSC_ADDR_PROC_DIS   12'h000
`define VSC_ADDR_STD        12'h004
`define VSC_ADDR_FMT_A      12'h00a
`define VSC_ADDR_FMT_B      12'h00b
// ---------------------------------------------------------------
// Processing-disable fields
// ---------------------------------------------------------------
`define VSC_BIT_TRS         0
`define VSC_BIT_LNUM        1
`define VSC_BIT_CRC         2
`define VSC_BIT_ANC         3
`define VSC_BIT_EDH         4
`define VSC_BIT_REMAP       5
`define VSC_BIT_PID         6
`define VSC_BIT_HCFG        8
`define VSC_PROC_DIS_MASK   16'h017f
`define VSC_PROC_DIS_RST    16'h0000
// ---------------------------------------------------------------
// Standard register fields
// ---------------------------------------------------------------
`define VSC_STD_CODE_LSB    10
`define VSC_STD_INT_BIT     9
`define VSC_STD_LOCK_BIT    8
// ---------------------------------------------------------------
// Total samples per line
// ---------------------------------------------------------------
`define VSC_TS_1650         13'd1650
`define VSC_TS_1980         13'd1980
`define VSC_TS_2200         13'd2200
`define VSC_TS_2376         13'd2376
`define VSC_TS_2640         13'd2640
`define VSC_TS_2750         13'd2750
`define VSC_TS_3300         13'd3300
`define VSC_TS_3960         13'd3960
`define VSC_TS_4125         13'd4125
`define VSC_TS_1716         13'd1716
`define VSC_TS_1728         13'd1728
// ---------------------------------------------------------------
// Active samples and active lines
// ---------------------------------------------------------------
`define VSC_AS_1280         12'd1280
`define VSC_AS_1920         12'd1920
`define VSC_AS_1440         12'd1440
`define VSC_AL_1035         11'd1035
`define VSC_AL_487          11'd487
`define VSC_AL_507          11'd507
`define VSC_AL_576          11'd576
// ---------------------------------------------------------------
// Format codes
// ---------------------------------------------------------------
`define VSC_C_720_60        5'h00
`define VSC_C_720_30        5'h02
`define VSC_C_720_50        5'h04
`define VSC_C_720_25        5'h06
`define VSC_C_720_24        5'h08
`define VSC_C_1080_60I      5'h0a
`define VSC_C_1080_30P      5'h0b
`define VSC_C_1080_50I      5'h0c
`define VSC_C_1080_25P      5'h0d
`define VSC_C_1080_25P_X    5'h0e
`define VSC_C_1080_25S_X    5'h0f
`define VSC_C_1080_24P      5'h10
`define VSC_C_1080_24S      5'h11
`define VSC_C_1080_24P_X    5'h12
`define VSC_C_1080_24S_X    5'h13
`define VSC_C_1080_50I_B    5'h14
`define VSC_C_1035_60I      5'h15
`define VSC_C_525_487       5'h16
`define VSC_C_525_507       5'h17
`define VSC_C_625_576       5'h18
`define VSC_C_525_487_G     5'h19
`define VSC_C_625_G         5'h1a
`define VSC_C_525_507_G     5'h1b
`define VSC_C_UNK_HD        5'h1d
`define VSC_C_UNK_SD        5'h1e
`endif

// file: vsc_classify.v
// Combinational mapping from measured raster to a five-bit format code
`include "vsc_defs.vh"
module vsc_classify (
   // Measured raster
   input  wire [12:0] total_samples,
   input  wire [11:0] active_samples,
   input  wire [10:0] active_lines,
   input  wire        interlaced,
   input  wire        segmented,
   input  wire        sd_mode,
   // Result
   output reg  [4:0]  code
);
   // Extended variants are any active width other than the plain 1280 or 1920 samples
   wire ext_hd = (active_samples != `VSC_AS_1280) && (active_samples != `VSC_AS_1920);
   wire sd_std = (active_samples == `VSC_AS_1440);

   // Rate families 59.94/60 share a raster, so they share a code
   always @* begin
      code = sd_mode ? `VSC_C_UNK_SD : `VSC_C_UNK_HD;
      if (sd_mode) begin
         case (total_samples)
            `VSC_TS_1716: begin
               if (active_lines == `VSC_AL_507)
                  code = sd_std ? `VSC_C_525_507 : `VSC_C_525_507_G;
               else
                  code = sd_std ? `VSC_C_525_487 : `VSC_C_525_487_G;
            end
            `VSC_TS_1728: code = sd_std ? `VSC_C_625_576 : `VSC_C_625_G;
            default:      code = `VSC_C_UNK_SD;
         endcase
      end else if (active_lines == `VSC_AL_1035) begin
         code = `VSC_C_1035_60I;
      end else begin
         case (total_samples)
            `VSC_TS_1650: code = `VSC_C_720_60 | {4'h0, ext_hd};
            `VSC_TS_3300: code = `VSC_C_720_30 | {4'h0, ext_hd};
            `VSC_TS_1980: code = `VSC_C_720_50 | {4'h0, ext_hd};
            `VSC_TS_3960: code = `VSC_C_720_25 | {4'h0, ext_hd};
            `VSC_TS_4125: code = `VSC_C_720_24 | {4'h0, ext_hd};
            `VSC_TS_2200:
               code = (interlaced | segmented) ? `VSC_C_1080_60I : `VSC_C_1080_30P;
            `VSC_TS_2640: begin
               if (ext_hd)
                  code = segmented ? `VSC_C_1080_25S_X : `VSC_C_1080_25P_X;
               else
                  code = (interlaced | segmented) ? `VSC_C_1080_50I : `VSC_C_1080_25P;
            end
            `VSC_TS_2750: begin
               if (ext_hd)
                  code = segmented ? `VSC_C_1080_24S_X : `VSC_C_1080_24P_X;
               else
                  code = segmented ? `VSC_C_1080_24S : `VSC_C_1080_24P;
            end
            `VSC_TS_2376: code = `VSC_C_1080_50I_B;
            default:      code = `VSC_C_UNK_HD;
         endcase
      end
   end
endmodule

// file: vsc_chk_props.sv
// Checker of the feature-enable and format-code outputs of the control block
module vsc_chk_props (
   // Clock and reset
   input wire        clk,
   input wire        rst,
   // Register port
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [11:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire [15:0] reg_rdata,
   // Pins and stream context
   input wire        processing_enable_pin, coding_bypass_pin, sd_mode, flywheel_locked,
   input wire        in_active_picture, h_blank_active, h_trs_bit,
   // Outputs under watch
   input wire        h_timing, timing_ref_en, line_number_en, line_crc_chroma_en,
   input wire        error_packet_en, remap_en, payload_id_luma_en,
   input wire [4:0]  video_format_code
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Both pins high opens the insertion path
   wire gate = processing_enable_pin & coding_bypass_pin;
   // First registered cycle after reset is skipped for relations that use past inputs
   reg  live;
   always @(posedge clk) begin
      live <= !rst;
   end
   // Shadow of the horizontal select bit, so both arms of the mux are checked
   reg  h_cfg;
   always @(posedge clk) begin
      if (rst)
         h_cfg <= 1'b0;
      else if (reg_wr && reg_addr == 12'h000)
         h_cfg <= reg_wdata[8];
   end
   AST_GATE: assert property (!gate |=> !(line_number_en | remap_en | error_packet_en))
      else $error("insertion feature active with a control pin low");
   AST_TRS_PINS: assert property (!gate |=> !timing_ref_en)
      else $error("timing words enabled with a control pin low");
   AST_LNUM_SD: assert property (sd_mode |=> !line_number_en)
      else $error("line numbers enabled in SD mode");
   AST_CRC_C_SD: assert property (sd_mode |=> !line_crc_chroma_en)
      else $error("chroma line CRC enabled in SD mode");
   AST_EDH_HD: assert property (!sd_mode |=> !error_packet_en)
      else $error("error packets enabled in HD mode");
   AST_PID_SD: assert property (sd_mode |=> !payload_id_luma_en)
      else $error("payload id enabled in SD mode");
   AST_REMAP_AP: assert property (!in_active_picture |=> !remap_en)
      else $error("remapping enabled outside active picture");
   AST_H_SEL: assert property (live |=>
      h_timing == ($past(h_cfg) ? $past(h_trs_bit) : $past(h_blank_active)))
      else $error("horizontal timing does not follow its selected input");
   AST_MASK: assert property (reg_rd && reg_addr == 12'h000 |=>
      reg_rdata[15:9] == 7'h00 && !reg_rdata[7])
      else $error("unused disable bits read nonzero");
   AST_CODE_CLR: assert property (!(coding_bypass_pin && flywheel_locked) |=>
      video_format_code == 5'h00)
      else $error("format code not cleared");
   AST_NO_RSVD: assert property (video_format_code != 5'h1c && video_format_code != 5'h1f)
      else $error("reserved format code reported");
   // Main scenarios
   COV_TRS: cover property (gate && !sd_mode ##1 timing_ref_en);
   COV_EDH: cover property (sd_mode && error_packet_en);
   COV_CODE: cover property (video_format_code == 5'h0f);
endmodule

// file: vsc_src_model.sv
// Parallel video source model: raster measurement of the selected test format
module vsc_src_model (
   // Format select from the bench
   input  wire  [4:0]  sel,
   // Raster measurement
   output logic [12:0] total_samples,
   output logic [11:0] active_samples,
   output logic [10:0] active_lines,
   output logic        interlaced,
   output logic        segmented,
   output logic        sd_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [38:0] r;
   // Rows: samples, active samples, lines, interlaced, segmented, SD
   always_comb begin
      case (sel)
         5'd0:  r = {13'd4125, 12'd1280, 11'd720, 3'b000};
         5'd1:  r = {13'd4125, 12'd3600, 11'd720, 3'b000};
         5'd2:  r = {13'd2200, 12'd1920, 11'd1080, 3'b100};
         5'd3:  r = {13'd2200, 12'd1920, 11'd1080, 3'b000};
         5'd4:  r = {13'd2640, 12'd1920, 11'd1080, 3'b100};
         5'd5:  r = {13'd2640, 12'd1920, 11'd1080, 3'b000};
         5'd6:  r = {13'd2640, 12'd2304, 11'd1080, 3'b000};
         5'd7:  r = {13'd2640, 12'd2304, 11'd1080, 3'b010};
         5'd8:  r = {13'd2750, 12'd1920, 11'd1080, 3'b000};
         5'd9:  r = {13'd2750, 12'd1920, 11'd1080, 3'b010};
         5'd10: r = {13'd2750, 12'd2400, 11'd1080, 3'b000};
         5'd11: r = {13'd2750, 12'd2400, 11'd1080, 3'b010};
         5'd12: r = {13'd2376, 12'd1920, 11'd1080, 3'b100};
         5'd13: r = {13'd2200, 12'd1920, 11'd1035, 3'b100};
         5'd14: r = {13'd1716, 12'd1440, 11'd487, 3'b101};
         5'd15: r = {13'd1716, 12'd1440, 11'd507, 3'b101};
         5'd16: r = {13'd1728, 12'd1440, 11'd576, 3'b101};
         5'd17: r = {13'd1716, 12'd720, 11'd487, 3'b101};
         5'd18: r = {13'd1728, 12'd720, 11'd576, 3'b101};
         5'd19: r = {13'd1716, 12'd720, 11'd507, 3'b101};
         5'd20: r = {13'd1234, 12'd1000, 11'd100, 3'b000};
         5'd22: r = {13'd2200, 12'd1920, 11'd1080, 3'b010};
         default: r = {13'd999, 12'd600, 11'd200, 3'b101};
      endcase
      {total_samples, active_samples, active_lines, interlaced, segmented, sd_flag} = r;
   end
endmodule

// file: tb.sv
// Self-checking bench of the format code and processing-enable block
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin \
   n_mismatch++; $display("wrong value at %0t ns: %s", $time, msg); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [15:0] reg_wdata = 16'h0000, d;
   logic        pe = 1'b0, bp = 1'b0, tb_sd = 1'b0, use_src = 1'b0, rv = 1'b0;
   logic        locked = 1'b0, hb = 1'b0, htrs = 1'b0, iap = 1'b0;
   logic [4:0]  sel = 5'h00;
   wire  [15:0] reg_rdata;
   wire  [12:0] ts;
   wire  [11:0] act_s;
   wire  [10:0] al;
   wire         il, seg, src_sd;
   wire  [8:0]  en;
   wire  [4:0]  code;
   wire         sd = use_src ? src_sd : tb_sd;
   int          n_mismatch = 0, samples_checked = 0, dis_m = 0, fa = 0, fb = 0;
   logic [4:0]  exp_code [0:22] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
      5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1b,
      5'h1d, 5'h1e, 5'h0a};
   // Free-running pixel clock
   always #4 clk = ~clk;
   vsc_src_model src (.sel(sel), .total_samples(ts), .active_samples(act_s),
      .active_lines(al), .interlaced(il), .segmented(seg), .sd_flag(src_sd));
   vsc_proc_ctrl uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .processing_enable_pin(pe),
      .coding_bypass_pin(bp), .sd_mode(sd), .raster_valid(rv), .flywheel_locked(locked),
      .total_samples(ts), .active_samples(act_s), .active_lines(al), .interlaced(il),
      .segmented(seg), .h_blank_active(hb), .h_trs_bit(htrs), .in_active_picture(iap),
      .h_timing(en[8]), .timing_ref_en(en[7]), .line_number_en(en[6]),
      .line_crc_luma_en(en[5]), .line_crc_chroma_en(en[4]), .anc_checksum_en(en[3]),
      .error_packet_en(en[2]), .remap_en(en[1]), .payload_id_luma_en(en[0]),
      .video_format_code(code));
   task automatic wr(input logic [11:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Expected enables from pins, stream context and the disable bits
   function automatic logic [8:0] exp_en();
      logic g;
      g = pe & bp;
      return {dis_m[8] ? htrs : hb, g & !dis_m[0], g & !dis_m[1] & !sd, g & !dis_m[2],
         g & !dis_m[2] & !sd, g & !dis_m[3], g & !dis_m[4] & sd, g & !dis_m[5] & iap,
         g & !dis_m[6] & !sd & ((fa | fb) != 0)};
   endfunction
   task automatic tally_and_finish();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'hecbf));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(12'h000, d); `CHK(d, 16'h0000, "disable reset")
      rd(12'h004, d); `CHK(d, 16'h0000, "standard reset")
      rd(12'h3ff, d); `CHK(d, 16'h0000, "unmapped read")
      wr(12'h000, 16'hffff);
      rd(12'h000, d); `CHK(d, 16'h017f, "unused disable bits")
      // Random disable bits, id bytes and pins against the model
      for (int i = 0; i < 60; i++) begin
         if (i % 3 == 0) begin
            d = (i == 0) ? 16'h0000 : 16'($urandom);
            wr(12'h000, d);
            dis_m = d & 16'h017f;
            rd(12'h000, d); `CHK(d, 16'(dis_m), "disable readback")
         end
         if (i % 5 == 4) begin
            fa = ($urandom % 2) ? int'($urandom % 65536) : 0;
            fb = ($urandom % 2) ? int'($urandom % 256) : 0;
            wr(12'h00a, 16'(fa));
            wr(12'h00b, 16'(fb));
         end
         @(posedge clk);
         {pe, bp} <= ($urandom % 4 != 0) ? 2'b11 : 2'($urandom);
         {tb_sd, iap, hb, htrs} <= 4'($urandom);
         repeat (2) @(posedge clk);
         #1 `CHK(en, exp_en(), "feature enables")
      end
      // Every raster in turn, bypass and lock held high
      for (int i = 0; i < 23; i++) begin
         @(posedge clk);
         {bp, locked, rv, use_src} <= 4'b1111;
         sel <= 5'(i);
         repeat (3) @(posedge clk);
         #1 `CHK(code, exp_code[i], "format code")
         wr(12'h004, 16'h0000);
         rd(12'h004, d);
         `CHK(d & 16'hfd00, {1'b0, exp_code[i], 10'h100}, "standard register")
      end
      // Bypass low, then lock low, clear the code
      @(posedge clk);
      bp <= 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK(code, 5'h00, "code with bypass low")
      @(posedge clk);
      {bp, locked} <= 2'b10;
      repeat (2) @(posedge clk);
      #1 `CHK(code, 5'h00, "code with lock low")
      rd(12'h004, d); `CHK(d, 16'h0000, "standard after lock loss")
      tally_and_finish();
   end
endmodule
bind vsc_proc_ctrl vsc_chk_props u_chk (.clk(clk), .rst(rst), .reg_rd(reg_rd),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_addr(reg_addr), .reg_rdata(reg_rdata), .processing_enable_pin(processing_enable_pin),
   .coding_bypass_pin(coding_bypass_pin), .sd_mode(sd_mode), .flywheel_locked(flywheel_locked),
   .in_active_picture(in_active_picture), .h_blank_active(h_blank_active),
   .h_trs_bit(h_trs_bit), .h_timing(h_timing), .timing_ref_en(timing_ref_en),
   .line_number_en(line_number_en), .line_crc_chroma_en(line_crc_chroma_en),
   .error_packet_en(error_packet_en), .remap_en(remap_en),
   .payload_id_luma_en(payload_id_luma_en), .video_format_code(video_format_code));
